// File: ahsp_pkg.sv
// Constants, types and pin map of the converter's serial host port.
// Assumes one core clock that oversamples every host pin (serial clock too).
// Operation
// - EOC output low from sampling end to ready.
// - EOC behaviour only in conversion mode 00.
// - Interrupt falls on ready; frame start clears.
// - Interrupt falling edge forces data output off.
// - Frame sync low at select: wait for pulse.
// - Frame sync falling clears counter, enables input.
// - Input stops at sixteen edges or select rise.
// - Data output off after sixteenth bit.
// - Sleep pin parks analogue; wake on start.
// - Serial clock shifts input and clocks conversion.
// - Words arrive MSB first; top nibble is command.
// - Plain mode samples input on rising edges.
// - Sync mode samples input on falling edges.
// - Data output off until first bit presented.
// - Plain mode advances output on rising edges.
// - Sync mode presents MSB, advances on falling.
// - Frame sync level at select fall picks mode.
// - Result frames send ten result bits, six pad.
// - Config read sends twelve bits after four.
// - Select falling clears counter, drives data output.
// - Start pin low samples; rising starts conversion.
// - Command 1010 writes the configuration word.
package ahsp_pkg;

  localparam int NPINS = 6;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_FS = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_SST = 4;
  localparam int PIN_SLP = 5;
  // Idle levels of the pins, index order as above.
  localparam logic [NPINS-1:0] PIN_IDLE = 6'h35;

  localparam int RES_W = 10;
  localparam int CFG_W = 12;
  localparam int CMD_W = 4;
  localparam int WORD_W = 16;

  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CMD_LEN = 5'h04;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam logic [5:0] RES_PAD = 6'h00;
  localparam logic [3:0] CFG_PAD = 4'h0;

  localparam logic [CMD_W-1:0] CMD_CH_LAST = 4'h7;
  localparam logic [CMD_W-1:0] CMD_SW_PD = 4'h8;
  localparam logic [CMD_W-1:0] CMD_RD_CFG = 4'h9;
  localparam logic [CMD_W-1:0] CMD_WR_CFG = 4'hA;
  localparam logic [CMD_W-1:0] CMD_TST_LO = 4'hB;
  localparam logic [CMD_W-1:0] CMD_TST_HI = 4'hD;

  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_INT_BIT = 2;
  localparam logic [1:0] MODE_ONESHOT = 2'h0;

  // Serial clock rising edges one conversion takes.
  localparam logic [7:0] CONV_EDGES = 8'h0B;
  localparam logic [7:0] CCNT_ZERO = 8'h00;
  localparam logic [7:0] CCNT_STEP = 8'h01;

  typedef enum logic [3:0] {
    AHSP_IDLE = 4'h1,
    AHSP_WAITFS = 4'h2,
    AHSP_SHIFT = 4'h4,
    AHSP_DONE = 4'h8
  } ahsp_frame_t;

endpackage : ahsp_pkg

// File: ahsp_pins_if.sv
// Synchronised pin levels and their edge pulses.
// Assumes the producer and consumer share the core clock.
interface ahsp_pins_if;
  logic [ahsp_pkg::NPINS-1:0] lvl;
  logic [ahsp_pkg::NPINS-1:0] rise;
  logic [ahsp_pkg::NPINS-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport snk (input lvl, input rise, input fall);
endinterface : ahsp_pins_if

// File: ahsp_pin_sync.sv
// Two-flop synchronisers and edge finders for all host pins.
// Assumes pins are asynchronous to the core clock.
module ahsp_pin_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ahsp_pkg::NPINS-1:0] pins_i,
  ahsp_pins_if.src pins
);
  import ahsp_pkg::*;

  typedef struct packed {
    logic [NPINS-1:0] meta;
    logic [NPINS-1:0] lvl;
    logic [NPINS-1:0] dly;
  } ahsp_sync_t;

  ahsp_sync_t s_q;
  ahsp_sync_t s_d;

  // The first stage feeds only the second; edges compare later stages.
  always_comb begin
    s_d.meta = pins_i;
    s_d.lvl = s_q.meta;
    s_d.dly = s_q.lvl;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= {PIN_IDLE, PIN_IDLE, PIN_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar gi = 0; gi < NPINS; gi++) begin : g_pin
    assign pins.lvl[gi] = s_q.lvl[gi];
    assign pins.rise[gi] = s_q.lvl[gi] & ~s_q.dly[gi];
    assign pins.fall[gi] = ~s_q.lvl[gi] & s_q.dly[gi];
  end

endmodule : ahsp_pin_sync

// File: ahsp_port.sv
// Serial host port: framing, command decode, result and config output,
// conversion sequencing, end-of-conversion or interrupt pin, sleep pin.
// Assumes the host drives the serial clock well below a quarter of the
// core clock, and the converter core hands back result_i when asked.
module ahsp_port (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic frame_sync_in_i,
  input wire logic sample_start_n_i,
  input wire logic hw_sleep_n_i,
  input wire logic [ahsp_pkg::RES_W-1:0] result_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic eoc_int_o,
  output logic [ahsp_pkg::CFG_W-1:0] config_word_o,
  output logic [ahsp_pkg::CMD_W-1:0] cmd_o,
  output logic cmd_valid_o,
  output logic conv_start_o,
  output logic sampling_o,
  output logic analog_off_o
);
  import ahsp_pkg::*;

  typedef struct packed {
    ahsp_frame_t st;
    logic fs_mode;
    logic [4:0] bitcnt;
    logic [WORD_W-1:0] isr;
    logic [WORD_W-1:0] osr;
    logic oe_n;
    logic kill;
    logic [CFG_W-1:0] cfg;
    logic [CMD_W-1:0] cmd;
    logic cmd_v;
    logic [RES_W-1:0] res;
    logic conv;
    logic [7:0] ccnt;
    logic eoc;
    logic sampling;
    logic sample_start_n;
    logic parked;
  } ahsp_core_t;

  ahsp_core_t r_q;
  ahsp_core_t r_d;

  ahsp_pins_if pins_bus ();
  logic [NPINS-1:0] pin_raw;

  assign pin_raw[PIN_CS] = cs_n_i;
  assign pin_raw[PIN_SCLK] = sclk_i;
  assign pin_raw[PIN_FS] = frame_sync_in_i;
  assign pin_raw[PIN_SDI] = sdi_i;
  assign pin_raw[PIN_SST] = sample_start_n_i;
  assign pin_raw[PIN_SLP] = hw_sleep_n_i;

  ahsp_pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(pin_raw),
    .pins(pins_bus)
  );

  logic cs_fall;
  logic cs_rise;
  logic fs_fall;
  logic fs_rise;
  logic fs_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic sst_fall;
  logic sst_rise;
  logic slp_lvl;
  logic sdi_lvl;
  logic shift_edge;
  logic int_mode;
  logic oneshot;
  logic [WORD_W-1:0] word;
  logic [CMD_W-1:0] nib;
  logic conv_cmd;
  logic [4:0] next_cnt;
  logic [7:0] next_ccnt;

  assign cs_fall = pins_bus.fall[PIN_CS];
  assign cs_rise = pins_bus.rise[PIN_CS];
  assign fs_fall = pins_bus.fall[PIN_FS];
  assign fs_rise = pins_bus.rise[PIN_FS];
  assign fs_lvl = pins_bus.lvl[PIN_FS];
  assign sclk_rise = pins_bus.rise[PIN_SCLK];
  assign sclk_fall = pins_bus.fall[PIN_SCLK];
  assign sst_fall = pins_bus.fall[PIN_SST];
  assign sst_rise = pins_bus.rise[PIN_SST];
  assign slp_lvl = pins_bus.lvl[PIN_SLP];
  assign sdi_lvl = pins_bus.lvl[PIN_SDI];

  // Sync mode works on falling serial clock edges, plain mode on rising.
  assign shift_edge = r_q.fs_mode ? sclk_fall : sclk_rise;
  assign int_mode = r_q.cfg[CFG_INT_BIT];
  assign oneshot = r_q.cfg[CFG_MODE_LSB+1:CFG_MODE_LSB] == MODE_ONESHOT;

  // Incoming bits enter at the bottom, so the first bit ends up as bit 15.
  assign word = {r_q.isr[WORD_W-2:0], sdi_lvl};
  assign nib = word[WORD_W-1:WORD_W-CMD_W];
  assign conv_cmd = (nib <= CMD_CH_LAST) ||
                    ((nib >= CMD_TST_LO) && (nib <= CMD_TST_HI));
  assign next_cnt = r_q.bitcnt + CNT_STEP;
  assign next_ccnt = r_q.ccnt + CCNT_STEP;

  always_comb begin
    logic restart;
    logic go;
    logic done;
    restart = 1'b0;
    go = 1'b0;
    done = 1'b0;
    r_d = r_q;
    r_d.cmd_v = 1'b0;
    r_d.sample_start_n = 1'b0;

    // Sleep pin parks the analogue side; wake needs a fresh start.
    if (!slp_lvl) begin
      r_d.parked = 1'b1;
    end else if (r_q.parked && (cs_fall || sst_fall)) begin
      r_d.parked = 1'b0;
    end

    // Extended sampling under control of the start pin.
    if (sst_fall) begin
      r_d.sampling = 1'b1;
    end
    if (sst_rise) begin
      go = 1'b1;
    end

    case (r_q.st)
      AHSP_IDLE: begin
        if (cs_fall) begin
          r_d.fs_mode = ~fs_lvl;
          restart = 1'b1;
          r_d.st = fs_lvl ? AHSP_SHIFT : AHSP_WAITFS;
        end
      end
      AHSP_WAITFS: begin
        if (fs_fall) begin
          restart = 1'b1;
          r_d.st = AHSP_SHIFT;
        end
      end
      AHSP_SHIFT: begin
        if (r_q.fs_mode && fs_fall) begin
          restart = 1'b1;
        end else if (shift_edge) begin
          r_d.isr = word;
          r_d.bitcnt = next_cnt;
          r_d.osr = {r_q.osr[WORD_W-2:0], 1'b0};
          if (next_cnt == CMD_LEN) begin
            if (word[CMD_W-1:0] == CMD_RD_CFG) begin
              // Later bits carry the config word.
              r_d.osr = {r_q.cfg, CFG_PAD};
            end
          end
          if (next_cnt == FRAME_LEN) begin
            // Input closes and the output lets go after the last bit.
            r_d.oe_n = 1'b1;
            r_d.st = AHSP_DONE;
            done = 1'b1;
          end
        end
      end
      AHSP_DONE: begin
        if (r_q.fs_mode && fs_fall) begin
          restart = 1'b1;
          r_d.st = AHSP_SHIFT;
        end
      end
      default: begin
        r_d.st = AHSP_IDLE;
      end
    endcase

    if (restart) begin
      r_d.bitcnt = CNT_ZERO;
      r_d.osr = {r_q.res, RES_PAD};
      r_d.oe_n = 1'b0;
      r_d.kill = 1'b0;
      r_d.st = AHSP_SHIFT;
      if (r_q.st == AHSP_IDLE && !fs_lvl) begin
        r_d.st = AHSP_WAITFS;
      end
    end

    // A full word is decoded; a frame cut short by select is dropped.
    if (done) begin
      r_d.cmd = nib;
      r_d.cmd_v = 1'b1;
      if (nib == CMD_WR_CFG) begin
        r_d.cfg = word[CFG_W-1:0];
      end
      if (nib == CMD_SW_PD) begin
        r_d.parked = 1'b1;
      end
      if (conv_cmd) begin
        go = 1'b1;
      end
    end

    if (cs_rise) begin
      r_d.st = AHSP_IDLE;
      r_d.oe_n = 1'b1;
    end

    // Interrupt cleared by a new frame; a ready in the same cycle wins.
    if (int_mode && (cs_fall || fs_rise)) begin
      r_d.eoc = 1'b1;
    end

    // Conversion counts serial clock edges, so the host must keep it up.
    if (go) begin
      r_d.conv = 1'b1;
      r_d.ccnt = CCNT_ZERO;
      // A start pin fall in the same cycle opens a new sampling phase.
      r_d.sampling = sst_fall;
      r_d.sample_start_n = 1'b1;
      if (!int_mode && oneshot) begin
        r_d.eoc = 1'b0;
      end
    end else if (r_q.conv && sclk_rise) begin
      r_d.ccnt = next_ccnt;
      if (next_ccnt == CONV_EDGES) begin
        r_d.conv = 1'b0;
        r_d.res = result_i;
        if (int_mode) begin
          r_d.eoc = 1'b0;
          r_d.kill = 1'b1;
        end else begin
          r_d.eoc = 1'b1;
        end
      end
    end

    if (r_d.kill) begin
      r_d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_q <= '0;
      r_q.st <= AHSP_IDLE;
      r_q.oe_n <= 1'b1;
      r_q.eoc <= 1'b1;
      r_q.cfg <= CFG_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign sdo_o = r_q.osr[WORD_W-1];
  assign sdo_oe_n_o = r_q.oe_n;
  assign eoc_int_o = r_q.eoc;
  assign config_word_o = r_q.cfg;
  assign cmd_o = r_q.cmd;
  assign cmd_valid_o = r_q.cmd_v;
  assign conv_start_o = r_q.sample_start_n;
  assign sampling_o = r_q.sampling;
  assign analog_off_o = r_q.parked;

endmodule : ahsp_port

// File: ahsp_port_asserts.sv
// Concurrent checks on the serial host port, bound to its top module.
// Assumes the pins pass a two-cycle synchroniser inside the port.
module ahsp_port_asserts (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic frame_sync_in_i,
  input wire logic sample_start_n_i,
  input wire logic hw_sleep_n_i,
  input wire logic sdo_oe_n_o,
  input wire logic eoc_int_o,
  input wire logic [ahsp_pkg::CFG_W-1:0] config_word_o,
  input wire logic [ahsp_pkg::CMD_W-1:0] cmd_o,
  input wire logic cmd_valid_o,
  input wire logic conv_start_o,
  input wire logic sampling_o,
  input wire logic analog_off_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ahsp_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Windows of five cycles cover the synchroniser plus the output flop.
  sequence s_plain_start;
    $fell(cs_n_i) && frame_sync_in_i;
  endsequence
  sequence s_int_fall;
    $fell(eoc_int_o) && config_word_o[CFG_INT_BIT];
  endsequence
  AST_OE_IDLE: assert property (cs_n_i [*5] |-> sdo_oe_n_o)
    else $error("data output driven while deselected");
  AST_OE_ON: assert property (s_plain_start |-> ##[1:5] !sdo_oe_n_o)
    else $error("data output not driven after select");
  AST_INT_OFF: assert property (s_int_fall |-> ##[0:1] sdo_oe_n_o)
    else $error("data output driven after interrupt");
  AST_INT_CLR: assert property ($fell(cs_n_i) && !eoc_int_o &&
    config_word_o[CFG_INT_BIT] |-> ##[1:5] eoc_int_o)
    else $error("interrupt not cleared by select");
  AST_EOC_MODE: assert property ($fell(eoc_int_o) |->
    config_word_o[CFG_INT_BIT] ||
    config_word_o[CFG_MODE_LSB+:2] == MODE_ONESHOT)
    else $error("end of conversion in wrong mode");
  AST_END_OFF: assert property (cmd_valid_o |-> ##[0:1] sdo_oe_n_o)
    else $error("data output driven after last bit");
  AST_CFG_SRC: assert property ($changed(config_word_o) |->
    ##[0:1] cmd_o == CMD_WR_CFG)
    else $error("config changed without write command");
  AST_CONV: assert property (cmd_valid_o && cmd_o <= CMD_CH_LAST |->
    ##[0:1] conv_start_o)
    else $error("channel command started no conversion");
  AST_SLEEP: assert property (!hw_sleep_n_i [*4] |-> analog_off_o)
    else $error("analogue not parked in sleep");
  AST_SAMPLE: assert property ($fell(sample_start_n_i) |->
    ##[1:5] sampling_o)
    else $error("start pin did not begin sampling");
endmodule : ahsp_port_asserts

bind ahsp_port ahsp_port_asserts ahsp_port_asserts_inst (.core_clk_i,
  .rst_i, .cs_n_i, .frame_sync_in_i, .sample_start_n_i, .hw_sleep_n_i,
  .sdo_oe_n_o, .eoc_int_o, .config_word_o, .cmd_o, .cmd_valid_o,
  .conv_start_o, .sampling_o, .analog_off_o);

// File: ahsp_host_model.sv
// Host serial port model: select, frame sync, serial clock and data.
// Assumes the core clock; half is the serial half period in cycles.
module ahsp_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic fs_o,
  output logic [15:0] rx_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int half = 4;
  initial begin
    {cs_n_o, sclk_o, sdi_o, fs_o, rx_o, done_o} = {4'h9, 16'h0000, 1'b0};
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // The serial clock stands still between frames and bursts.
  task automatic burst(input int n);
    repeat (n) begin
      sclk_o <= 1'b1;
      tick(half);
      sclk_o <= 1'b0;
      tick(half);
    end
  endtask : burst
  // Select alone, for frames that the bench cuts short by hand.
  task automatic select(input logic lvl);
    cs_n_o <= lvl;
  endtask : select
  task automatic xfer(input logic [15:0] w, input logic sm);
    logic [15:0] r;
    fs_o <= ~sm;
    cs_n_o <= 1'b0;
    tick(6);
    if (sm) begin
      fs_o <= 1'b1;
      tick(half);
      fs_o <= 1'b0;
      tick(2);
    end
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= sm;
      sdi_o <= w[i];
      tick(half);
      r[i] = sdo_oe_n_i ? 1'bx : sdo_i;
      sclk_o <= ~sm;
      tick(half);
    end
    sdi_o <= ~w[0];
    sclk_o <= 1'b0;
    tick(2);
    {cs_n_o, fs_o, rx_o, done_o} <= {2'h3, r, 1'b1};
    tick(1);
    done_o <= 1'b0;
  endtask : xfer
endmodule : ahsp_host_model

// File: testbench.sv
// Self-checking bench of the serial host port with a host model.
// Assumes a 50 MHz core clock and a 160 ns serial clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ahsp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sample_start_n_i = 1'b1;
  logic hw_sleep_n_i = 1'b1;
  logic [RES_W-1:0] result_i = 10'h000;
  logic cs_n_i, sclk_i, sdi_i, frame_sync_in_i, sdo_o, sdo_oe_n_o, eoc_int_o;
  logic cmd_valid_o, conv_start_o, sampling_o, analog_off_o, done;
  logic [CFG_W-1:0] config_word_o;
  logic [CMD_W-1:0] cmd_o;
  logic [15:0] rx;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic [CFG_W-1:0] cfg;
  logic [RES_W-1:0] res;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  ahsp_port ahsp_port_inst (.core_clk_i, .rst_i, .cs_n_i, .sclk_i, .sdi_i,
    .frame_sync_in_i, .sample_start_n_i, .hw_sleep_n_i, .result_i, .sdo_o,
    .sdo_oe_n_o, .eoc_int_o, .config_word_o, .cmd_o, .cmd_valid_o,
    .conv_start_o, .sampling_o, .analog_off_o);
  ahsp_host_model ahsp_host_model_inst (.clk_i(core_clk_i), .sdo_i(sdo_o),
    .sdo_oe_n_i(sdo_oe_n_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .sdi_o(sdi_i), .fs_o(frame_sync_in_i), .rx_o(rx), .done_o(done));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // A note holds the compare mask above the expected word.
  task automatic frame(input logic [15:0] w, input logic sm,
    input logic [31:0] n);
    exp_q.push_back(n);
    ahsp_host_model_inst.xfer(w, sm);
  endtask : frame
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      stop_test();
    end else if (done) begin
      note = exp_q.pop_front();
      chk("sdo word", note[15:0], {16'h0000, rx & note[31:16]});
    end
  end
  initial begin
    cfg = 12'($urandom(91150));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    res = 10'($urandom);
    result_i <= res;
    frame(16'hA000, 1'b0, 32'h0);
    chk("config", 32'(CFG_RESET), 32'(config_word_o));
    frame(16'h0000, 1'b0, 32'h0);
    chk("eoc low", 32'h0, 32'(eoc_int_o));
    ahsp_host_model_inst.burst(12);
    chk("eoc high", 32'h1, 32'(eoc_int_o));
    frame(16'hE000, 1'b0, {16'hFFFF, res, RES_PAD});
    frame(16'hE000, 1'b1, {16'hFFFF, res, RES_PAD});
    cfg = (cfg & 12'hF9F) | 12'h004;
    frame({CMD_WR_CFG, cfg}, 1'b0, 32'h0);
    chk("config", 32'(cfg), 32'(config_word_o));
    frame({CMD_RD_CFG, 12'h000}, 1'b1, {16'h0FFF, CFG_PAD, cfg});
    frame(16'h1000, 1'b0, 32'h0);
    chk("int idle", 32'h1, 32'(eoc_int_o));
    // Select stays low, so only the interrupt can turn the output off.
    ahsp_host_model_inst.select(1'b0);
    ahsp_host_model_inst.burst(12);
    chk("int set", 32'h0, 32'(eoc_int_o));
    chk("sdo off", 32'h1, 32'(sdo_oe_n_o));
    ahsp_host_model_inst.select(1'b1);
    repeat (4) @(posedge core_clk_i);
    frame(16'hE000, 1'b0, {16'hFFFF, res, RES_PAD});
    chk("int clear", 32'h1, 32'(eoc_int_o));
    for (int c = 0; c < 15; c++) begin
      frame({4'(c), 12'h000}, c[0], 32'h0);
      chk("command", 32'(c), 32'(cmd_o));
    end
    hw_sleep_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk("sleep", 32'h1, 32'(analog_off_o));
    hw_sleep_n_i <= 1'b1;
    sample_start_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk("sampling", 32'h1, 32'(sampling_o));
    chk("wake", 32'h0, 32'(analog_off_o));
    sample_start_n_i <= 1'b1;
    ahsp_host_model_inst.burst(12);
    stop_test();
  end
endmodule : testbench
